// ### core/rsl_consts.vh
// Constants of the retriggerable state latch: register offsets, fields, resets, timing.
// Assumes a 250 MHz system clock and a classic Wishbone register port.
`ifndef RSL_CONSTS_VH
`define RSL_CONSTS_VH
// Register byte offsets
`define RSL_REG_CTRL      8'h00
`define RSL_REG_HOLD      8'h04
`define RSL_REG_STATUS    8'h08
`define RSL_REG_IRQ_STAT  8'h0C
`define RSL_REG_IRQ_MASK  8'h10
`define RSL_REG_LEAK      8'h14
// Control fields
`define RSL_CTRL_EN       0
`define RSL_CTRL_POL      1
`define RSL_CTRL_LEAK     2
// Reset values: latch on, high active, leak mode off
`define RSL_CTRL_RESET    3'h3
// Hold period in ms, one minute by default
`define RSL_HOLD_MS_RESET 32'h0000_EA60
// Clock rate in kHz: ticks per millisecond
`define RSL_CLK_KHZ       250000
`define RSL_TICK_MS       1
// Interrupt bits
`define RSL_IRQ_RISE      0
`define RSL_IRQ_EXPIRE    1
`define RSL_IRQ_FAULT     2
`define RSL_IRQ_W         3
`endif

// ### core/rsl_ms_tick.v
// Millisecond time base: one-cycle enable pulse from a free divider.
// Assumes one clock and a synchronous active-high reset.
`include "rsl_consts.vh"
module rsl_ms_tick #(
   parameter integer DIV = `RSL_CLK_KHZ * `RSL_TICK_MS
) (
   input  wire CLOCK,
   input  wire RESET,
   output reg  TICK
);
   // Counter wide enough for the default divide
   reg [17:0] count;

   // Divider wraps and pulses once per period
   always @(posedge CLOCK) begin
      if (RESET) begin
         count <= 18'h0_0000;
         TICK  <= 1'b0;
      end else if (count == DIV[17:0] - 18'h0_0001) begin
         count <= 18'h0_0000;
         TICK  <= 1'b1;
      end else begin
         count <= count + 18'h0_0001;
         TICK  <= 1'b0;
      end
   end
endmodule // rsl_ms_tick

// ### core/rsl_latch.v
// Retriggerable state latch for one discrete field channel with Wishbone registers.
// Assumes the sensor pins are asynchronous and the host reads the reported values.
//
// Behaviour
// - Enabled latch holds momentary activations for period
// - Active level selectable, high or low
// - Defaults: enabled, high active, one minute
// - Short activation reported for whole hold period
// - Hold timer starts at entry to active
// - Only activations latch; inactive never held
// - Re-armed once reported value is released
// - Reactivation during hold restarts full period
// - Report latched value while latching enabled
// - Leak mode: one/one means normal, healthy
// - Leak mode: primary zero means leak detected
// - Leak mode: one/zero means sensor disconnected
//
// The address map and the Wishbone slave port were decided locally.
`include "rsl_consts.vh"
module rsl_latch #(
   parameter integer TICK_DIV = `RSL_CLK_KHZ * `RSL_TICK_MS // Clocks per millisecond
) (
   input  wire        CLOCK,
   input  wire        RESET,
   input  wire        SENSE_IN,
   input  wire        SENSOR_OK_IN,
   input  wire        WB_CYC_I,
   input  wire        WB_STB_I,
   input  wire        WB_WE_I,
   input  wire [7:0]  WB_ADR_I,
   input  wire [3:0]  WB_SEL_I,
   input  wire [31:0] WB_DAT_I,
   output reg  [31:0] WB_DAT_O,
   output reg         WB_ACK_O,
   output wire        IRQ,
   output reg         REPORTED_STATE,
   output reg         PRIMARY_REPORTED_VALUE,
   output reg         SECONDARY_REPORTED_VALUE
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   reg [2:0]  ctrl;               // Enable, polarity, leak mode
   reg [31:0] hold_ms;            // Hold period in milliseconds
   reg [31:0] remain;             // Milliseconds left of current hold
   reg        holding;            // Hold in progress
   reg [2:0]  irq_stat;           // Sticky event bits
   reg [2:0]  irq_mask;           // Interrupt enables
   reg        sense_m;            // Synchroniser stage one
   reg        sense_s;            // Synchroniser stage two
   reg        ok_m;               // Sensor health stage one
   reg        ok_s;               // Sensor health stage two
   reg        active_d;           // Previous active sample
   reg [2:0]  next_irq_stat;      // Status after set and clear
   wire       tick;               // Millisecond enable
   wire       active;             // Input in its active state
   wire       rise;               // Entry into active state
   wire       expire;             // Hold timer runs out this tick
   wire       bus_req;            // Valid Wishbone cycle
   wire       wr;                 // Write strobe, one per cycle
   wire       fault;              // Sensor unhealthy while leak mode is on
   wire [31:0] ctrl_wr;           // Control word after byte-lane merge
   wire [31:0] mask_wr;           // Mask word after byte-lane merge

   ////////////////////////////////////////////////////////////////////////////
   // Time base
   rsl_ms_tick #(
      .DIV   (TICK_DIV)
   ) u_tick (
      .CLOCK (CLOCK),
      .RESET (RESET),
      .TICK  (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Byte-lane merge used by the control, hold and mask registers
   function [31:0] merge;
      input [31:0] old;
      input [31:0] new_val;
      input [3:0]  sel;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               merge[i*8 +: 8] = new_val[i*8 +: 8];
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; only the second stage is read
   always @(posedge CLOCK) begin
      if (RESET) begin
         sense_m <= 1'b0;
         sense_s <= 1'b0;
         ok_m    <= 1'b1;
         ok_s    <= 1'b1;
      end else begin
         sense_m <= SENSE_IN;
         sense_s <= sense_m;
         ok_m    <= SENSOR_OK_IN;
         ok_s    <= ok_m;
      end
   end

   // Polarity selects which level counts as active
   assign active = sense_s ^ ctrl[`RSL_CTRL_POL] ^ 1'b1;
   // Only entries into active count as events
   assign rise   = active & ~active_d;
   assign expire = holding & tick & (remain <= 32'h0000_0001);
   assign fault  = ctrl[`RSL_CTRL_LEAK] & ~ok_s;

   ////////////////////////////////////////////////////////////////////////////
   // Hold timer: starts or restarts on every activation while enabled
   always @(posedge CLOCK) begin
      if (RESET) begin
         active_d <= 1'b0;
         holding  <= 1'b0;
         remain   <= 32'h0000_0000;
      end else begin
         active_d <= active;
         if (!ctrl[`RSL_CTRL_EN]) begin
            // Latch off: nothing held
            holding <= 1'b0;
            remain  <= 32'h0000_0000;
         end else if (rise) begin
            // Timer begins at entry, not at release
            holding <= 1'b1;
            remain  <= hold_ms;
         end else if (expire) begin
            // Released here, so next rise re-arms
            holding <= 1'b0;
            remain  <= 32'h0000_0000;
         end else if (holding && tick) begin
            remain  <= remain - 32'h0000_0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reported values
   always @(posedge CLOCK) begin
      if (RESET) begin
         REPORTED_STATE           <= 1'b0;
         PRIMARY_REPORTED_VALUE   <= 1'b1;
         SECONDARY_REPORTED_VALUE <= 1'b1;
      end else begin
         if (ctrl[`RSL_CTRL_EN]) begin
            // Held level, or live input after hold ends
            REPORTED_STATE <= holding | active | rise;
         end else begin
            REPORTED_STATE <= active;
         end
         if (ctrl[`RSL_CTRL_LEAK]) begin
            // Leak active gives zero primary; health on secondary
            if (!ok_s) begin
               PRIMARY_REPORTED_VALUE   <= 1'b1;
               SECONDARY_REPORTED_VALUE <= 1'b0;
            end else begin
               PRIMARY_REPORTED_VALUE   <= ~(holding | active | rise);
               SECONDARY_REPORTED_VALUE <= 1'b1;
            end
         end else begin
            PRIMARY_REPORTED_VALUE   <= 1'b1;
            SECONDARY_REPORTED_VALUE <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave: one registered ack after one wait state, dropped the cycle after
   assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   // Writes land on the ack edge, where the master takes the answer
   assign wr      = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I;
   // Merged words; only the low bits are kept below
   assign ctrl_wr = merge({29'h0, ctrl}, WB_DAT_I, WB_SEL_I);
   assign mask_wr = merge({29'h0, irq_mask}, WB_DAT_I, WB_SEL_I);

   // Sticky status: hardware set wins over write-one clear
   always @* begin
      next_irq_stat = irq_stat;
      if (wr && WB_ADR_I == `RSL_REG_IRQ_STAT && WB_SEL_I[0]) begin
         next_irq_stat = irq_stat & ~WB_DAT_I[2:0];
      end
      next_irq_stat[`RSL_IRQ_RISE]   = next_irq_stat[`RSL_IRQ_RISE] | rise;
      next_irq_stat[`RSL_IRQ_EXPIRE] = next_irq_stat[`RSL_IRQ_EXPIRE] | expire;
      next_irq_stat[`RSL_IRQ_FAULT]  = next_irq_stat[`RSL_IRQ_FAULT] | fault;
   end

   // Register writes and bus answer
   always @(posedge CLOCK) begin
      if (RESET) begin
         ctrl     <= `RSL_CTRL_RESET;
         hold_ms  <= `RSL_HOLD_MS_RESET;
         irq_stat <= 3'h0;
         irq_mask <= 3'h0;
         WB_ACK_O <= 1'b0;
      end else begin
         WB_ACK_O <= bus_req;
         irq_stat <= next_irq_stat;
         if (wr) begin
            if (WB_ADR_I == `RSL_REG_CTRL) begin
               ctrl <= ctrl_wr[2:0];
            end else if (WB_ADR_I == `RSL_REG_HOLD) begin
               hold_ms <= merge(hold_ms, WB_DAT_I, WB_SEL_I);
            end else if (WB_ADR_I == `RSL_REG_IRQ_MASK) begin
               irq_mask <= mask_wr[2:0];
            end
         end
      end
   end

   // Read data; unmapped offsets read zero
   always @(posedge CLOCK) begin
      if (RESET) begin
         WB_DAT_O <= 32'h0000_0000;
      end else if (bus_req && !WB_WE_I) begin
         if (WB_ADR_I == `RSL_REG_CTRL) begin
            WB_DAT_O <= {29'h0, ctrl};
         end else if (WB_ADR_I == `RSL_REG_HOLD) begin
            WB_DAT_O <= hold_ms;
         end else if (WB_ADR_I == `RSL_REG_STATUS) begin
            WB_DAT_O <= {28'h0, holding, active, ok_s, REPORTED_STATE};
         end else if (WB_ADR_I == `RSL_REG_IRQ_STAT) begin
            WB_DAT_O <= {29'h0, irq_stat};
         end else if (WB_ADR_I == `RSL_REG_IRQ_MASK) begin
            WB_DAT_O <= {29'h0, irq_mask};
         end else if (WB_ADR_I == `RSL_REG_LEAK) begin
            WB_DAT_O <= {30'h0, SECONDARY_REPORTED_VALUE, PRIMARY_REPORTED_VALUE};
         end else begin
            WB_DAT_O <= 32'h0000_0000;
         end
      end
   end

   // Level interrupt while any unmasked event is pending
   assign IRQ = |(irq_stat & irq_mask);
endmodule // rsl_latch

// ### test/rsl_field.sv
// Field side model: discrete contact and leak sensor health lines.
// Assumes the bench sets the wanted levels just after a clock edge.
module rsl_field (
   input  wire logic CLOCK,
   input  wire logic LEVEL,
   input  wire logic OK,
   output logic      SENSE_IN,
   output logic      SENSOR_OK_IN
);
   timeunit 1ns;
   timeprecision 1ps;
   // Contacts settle one cycle after the bench asks
   always @(posedge CLOCK) begin
      SENSE_IN     <= LEVEL;
      SENSOR_OK_IN <= OK;
   end
endmodule // rsl_field

// ### test/rsl_latch_chk.sv
// Checker for the latch: bus timing, latch timing, leak mapping.
// Assumes it is bound to the latch and sees only its ports.
`include "rsl_consts.vh"
module rsl_latch_chk (
   input wire logic        CLOCK, RESET, SENSE_IN, SENSOR_OK_IN,
   input wire logic        WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O,
   input wire logic [7:0]  WB_ADR_I,
   input wire logic [3:0]  WB_SEL_I,
   input wire logic [31:0] WB_DAT_I, WB_DAT_O,
   input wire logic        REPORTED_STATE, PRIMARY_REPORTED_VALUE, SECONDARY_REPORTED_VALUE
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] ctrl;                   // Shadow control: enable, polarity, leak
   wire  req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire  en   = ctrl[`RSL_CTRL_EN];
   wire  leak = ctrl[`RSL_CTRL_LEAK];
   wire  act  = SENSE_IN ~^ ctrl[`RSL_CTRL_POL];
   wire  pri  = PRIMARY_REPORTED_VALUE;
   wire  sec  = SECONDARY_REPORTED_VALUE;
   // Follow control writes at the edge the bus takes them
   always @(posedge CLOCK) begin
      if (RESET)
         ctrl <= 3'h3;
      else if (WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I & WB_SEL_I[0] &
               (WB_ADR_I == `RSL_REG_CTRL))
         ctrl <= WB_DAT_I[2:0];
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   property p_ack_next; req |=> WB_ACK_O; endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not acked");
   property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than a cycle");
   property p_unmapped; req && !WB_WE_I && WB_ADR_I > 8'h14 |=> WB_DAT_O == 32'h0000_0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_rise; en && $rose(act) |-> ##[1:5] REPORTED_STATE; endproperty
   a_rise: assert property (p_rise) else $error("activation not reported");
   // A fall needs the input gone inactive first
   property p_no_drop;
      $fell(REPORTED_STATE) && en |-> !($past(act, 2) && $past(act, 3) && $past(act, 4));
   endproperty
   a_no_drop: assert property (p_no_drop) else $error("dropped while active");
   property p_live; (!en && $stable(SENSE_IN) && $stable(ctrl))[*5] |-> REPORTED_STATE == act;
   endproperty
   a_live: assert property (p_live) else $error("disabled not live");
   property p_leak_off; !leak && $past(!leak) |-> pri && sec; endproperty
   a_leak_off: assert property (p_leak_off) else $error("values not one");
   property p_open; (leak && !SENSOR_OK_IN)[*5] |-> pri && !sec; endproperty
   a_open: assert property (p_open) else $error("open sensor not flagged");
   property p_leak; (leak && SENSOR_OK_IN && act)[*5] |-> !pri && sec; endproperty
   a_leak: assert property (p_leak) else $error("leak not flagged");
   c_rise: cover property (en && $rose(act));
   c_open: cover property (leak && !SENSOR_OK_IN);
   c_unmapped: cover property (req && WB_ADR_I > 8'h14);
endmodule // rsl_latch_chk
bind rsl_latch rsl_latch_chk chk_u (.CLOCK(CLOCK), .RESET(RESET), .SENSE_IN(SENSE_IN),
   .SENSOR_OK_IN(SENSOR_OK_IN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
   .WB_ACK_O(WB_ACK_O), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O), .REPORTED_STATE(REPORTED_STATE),
   .PRIMARY_REPORTED_VALUE(PRIMARY_REPORTED_VALUE),
   .SECONDARY_REPORTED_VALUE(SECONDARY_REPORTED_VALUE));

// ### test/rsl_latch_tb.sv
// Bench for the latch: registers, latch timing, interrupt, leak mode.
// Assumes the field model feeds the pins; a short tick divide keeps holds brief.
`include "rsl_consts.vh"
module rsl_latch_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, reset, cyc, stb, we, level, ok, ack, irq, rep, pri, sec, sense, sok;
   logic [7:0]  adr;
   logic [31:0] wdat, dat_o, q;
   int          mismatches, num_checks, cycles;
   rsl_field fld_u (.CLOCK(clock), .LEVEL(level), .OK(ok), .SENSE_IN(sense), .SENSOR_OK_IN(sok));
   // One ms tick every 100 clocks so whole holds fit the run
   rsl_latch #(.TICK_DIV(100)) dut_u (.CLOCK(clock), .RESET(reset), .SENSE_IN(sense),
      .SENSOR_OK_IN(sok),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
      .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .IRQ(irq), .REPORTED_STATE(rep),
      .PRIMARY_REPORTED_VALUE(pri), .SECONDARY_REPORTED_VALUE(sec));
   initial begin
      clock = 0;
      forever #2 clock = ~clock;
   end
   // Hang guard: all holds together take a few thousand cycles
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic ck(input string n, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   // One classic cycle, held until ack is seen
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clock); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic nc(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Bounded wait for the reported value
   task automatic till(input logic v);
      for (int i = 0; i < 2000 && rep !== v; i++) @(posedge clock);
   endtask
   // Three-cycle excursion of the contact
   task automatic pulse(input logic v);
      level <= v;
      nc(3);
      level <= ~v;
      nc(8);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      {cyc, stb, we, level, adr, wdat} = 0;
      ok = 1;
      reset = 1;
      nc(6);
      reset <= 0;
      wb(0, `RSL_REG_CTRL, 0);
      ck("ctrl", 32'h0000_0003, q);
      wb(0, `RSL_REG_HOLD, 0);
      ck("hold", 32'h0000_EA60, q);
      wb(0, 8'h18, 0);
      ck("unmapped", 0, q);
      // Host picks a hold well above the reporting delay
      wb(1, `RSL_REG_HOLD, 5);
      pulse(1);
      ck("short", 1, rep);
      nc(300);
      ck("held", 1, rep);
      wb(0, `RSL_REG_IRQ_STAT, 0);
      ck("irq stat", 1, q[`RSL_IRQ_RISE]);
      wb(1, `RSL_REG_IRQ_MASK, 1);
      nc(1);
      ck("irq on", 1, irq);
      wb(1, `RSL_REG_IRQ_STAT, 1);
      nc(1);
      ck("irq off", 0, irq);
      wb(0, `RSL_REG_HOLD, 0);
      ck("hold wr", 32'h0000_0005, q);
      till(0);
      ck("expire", 0, rep);
      level <= 1;
      nc(700);
      ck("long", 1, rep);
      level <= 0;
      nc(8);
      ck("follow", 0, rep);
      pulse(1);
      ck("rearm", 1, rep);
      wb(1, `RSL_REG_CTRL, 1);
      level <= 1;
      till(0);
      pulse(0);
      ck("low active", 1, rep);
      wb(1, `RSL_REG_CTRL, 2);
      level <= 0;
      nc(8);
      pulse(1);
      ck("disabled", 0, rep);
      wb(1, `RSL_REG_CTRL, 7);
      nc(8);
      ck("normal", 2'b11, {pri, sec});
      ok <= 0;
      nc(8);
      ck("open", 2'b10, {pri, sec});
      ok <= 1;
      level <= 1;
      nc(8);
      ck("leak", 0, pri);
      close_out();
   end
endmodule // rsl_latch_tb
